// >>> design/safety_stop_monitor.sv
`timescale 1ns/10ps
`include "safety_stop_cfg.svh"
module safety_stop_monitor (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic                    power_ok_i,
  input  wire logic                    stop_channel_one_i,
  input  wire logic                    stop_channel_two_i,
  input  wire logic                    guard_fault_i,
  input  wire logic                    cpu_fault_i,
  input  wire logic                    running_i,
  input  wire safety_stop_pkg::wb_req_t wb_req_i,
  output safety_stop_pkg::wb_rsp_t     wb_rsp_o,
  output safety_stop_pkg::term_out_t   term_o,
  output logic                         drive_enable_o,
  output logic                         stop_requested_indication_o,
  output logic [1:0]                   fault_code_o,
  output logic                         irq_o
);
  import safety_stop_pkg::*;

  // channel inputs: high means shorted to channel_common
  logic        open_one;
  logic        open_two;
  logic        any_fault;
  assign open_one  = !stop_channel_one_i;
  assign open_two  = !stop_channel_two_i;
  assign any_fault = guard_fault_i || cpu_fault_i;

  // combinational decision of the safety state
  stop_state_t state_now;
  assign state_now = (open_one != open_two) ? ST_SPLIT :
                     any_fault              ? ST_FAULT :
                     (open_one && open_two) ? ST_STOPPED :
                                              ST_ENABLED;

  // status levels, high = transistor conducts
  logic mon_on;
  logic health_on;
  logic enable_now;
  assign mon_on     = power_ok_i && (state_now == ST_STOPPED);
  assign health_on  = power_ok_i && !any_fault &&
                      (state_now != ST_SPLIT);
  assign enable_now = power_ok_i && (state_now == ST_ENABLED);

  // registers
  logic [8:0] sel_run_reg;
  logic [8:0] sel_two_reg;
  logic [8:0] sel_thr_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic       sw_enable_reg;
  logic       ack_reg;
  logic [31:0] rdat_reg;
  stop_state_t state_reg;

  // terminal function mapping per selector
  function automatic logic map_term(input logic [8:0] sel,
                                    input logic mon, input logic hl,
                                    input logic dflt);
    logic r;
    r = dflt;
    if (sel == {1'b0, `SS_SEL_MON_POS})        r = mon;
    else if (sel == `SS_SEL_MON_NEG)           r = !mon;
    else if (sel == {1'b0, `SS_SEL_HEALTH_POS}) r = hl;
    else if (sel == `SS_SEL_HEALTH_NEG)        r = !hl;
    return r;
  endfunction

  // monitor pin keeps monitor unless routed elsewhere
  logic routed_mon;
  assign routed_mon =
    (sel_run_reg == {1'b0, `SS_SEL_MON_POS}) ||
    (sel_run_reg == `SS_SEL_MON_NEG) ||
    (sel_two_reg == {1'b0, `SS_SEL_MON_POS}) ||
    (sel_two_reg == `SS_SEL_MON_NEG) ||
    (sel_thr_reg == {1'b0, `SS_SEL_MON_POS}) ||
    (sel_thr_reg == `SS_SEL_MON_NEG);

  term_out_t term_next;
  assign term_next.mon_pin     = routed_mon ? 1'b0 : mon_on;
  assign term_next.run_term    = map_term(sel_run_reg, mon_on, health_on,
                                          running_i && enable_now);
  assign term_next.second_term = map_term(sel_two_reg, mon_on, health_on,
                                          1'b0);
  assign term_next.third_term  = map_term(sel_thr_reg, mon_on, health_on,
                                          1'b0);

  // fault code: guard code before processor code
  logic [1:0] code_next;
  assign code_next = guard_fault_i ? `SS_CODE_GUARD :
                     cpu_fault_i   ? `SS_CODE_CPU : `SS_CODE_NONE;

  // wishbone decode
  logic wb_hit;
  logic wr_go;
  logic rd_known;
  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
  assign wr_go  = wb_hit && wb_req_i.we && wb_req_i.sel[0];
  assign rd_known = (wb_req_i.adr == `SS_OFF_CTRL) ||
                    (wb_req_i.adr == `SS_OFF_STATUS) ||
                    (wb_req_i.adr == `SS_OFF_IRQ_STAT) ||
                    (wb_req_i.adr == `SS_OFF_IRQ_MASK) ||
                    (wb_req_i.adr == `SS_OFF_SEL_RUN) ||
                    (wb_req_i.adr == `SS_OFF_SEL_TWO) ||
                    (wb_req_i.adr == `SS_OFF_SEL_THR);

  logic [31:0] rd_mux;
  assign rd_mux =
    (wb_req_i.adr == `SS_OFF_CTRL)     ? {31'h0, sw_enable_reg} :
    (wb_req_i.adr == `SS_OFF_STATUS)   ? {24'h0, state_reg, fault_code_o,
                                          stop_requested_indication_o,
                                          drive_enable_o} :
    (wb_req_i.adr == `SS_OFF_IRQ_STAT) ? {28'h0, irq_stat_reg} :
    (wb_req_i.adr == `SS_OFF_IRQ_MASK) ? {28'h0, irq_mask_reg} :
    (wb_req_i.adr == `SS_OFF_SEL_RUN)  ? {23'h0, sel_run_reg} :
    (wb_req_i.adr == `SS_OFF_SEL_TWO)  ? {23'h0, sel_two_reg} :
    (wb_req_i.adr == `SS_OFF_SEL_THR)  ? {23'h0, sel_thr_reg} : 32'h0;

  // 9-bit selector write from low two lanes
  function automatic logic [8:0] sel_wr(input logic [8:0] old);
    logic [8:0] v;
    v = old;
    if (wb_req_i.sel[0]) v[7:0] = wb_req_i.dat[7:0];
    if (wb_req_i.sel[1]) v[8]   = wb_req_i.dat[8];
    return v;
  endfunction
  logic wr_any;
  assign wr_any = wb_hit && wb_req_i.we;

  // event detection
  logic [3:0] ev_now;
  assign ev_now[`SS_IRQ_STOP]     = (state_now == ST_STOPPED) &&
                                    (state_reg != ST_STOPPED);
  assign ev_now[`SS_IRQ_FAULT]    = (state_now == ST_FAULT) &&
                                    (state_reg != ST_FAULT);
  assign ev_now[`SS_IRQ_MISMATCH] = (state_now == ST_SPLIT) &&
                                    (state_reg != ST_SPLIT);
  // enable event follows the registered enable, so it fires once per rise
  assign ev_now[`SS_IRQ_ENABLE]   = enable_now && sw_enable_reg &&
                                    !drive_enable_o;

  logic [3:0] clr_bits;
  assign clr_bits = (wr_go && wb_req_i.adr == `SS_OFF_IRQ_STAT) ?
                    wb_req_i.dat[3:0] : 4'h0;
  logic [3:0] irq_stat_next;
  assign irq_stat_next = (irq_stat_reg & ~clr_bits) | ev_now; // set wins

  // bus slave and control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg      <= 1'b0;
      rdat_reg     <= 32'h0000_0000;
      sel_run_reg  <= `SS_SEL_RESET;
      sel_two_reg  <= `SS_SEL_RESET;
      sel_thr_reg  <= `SS_SEL_RESET;
      irq_mask_reg <= `SS_MASK_RESET;
      sw_enable_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg  <= wb_hit;
      rdat_reg <= (wb_hit && rd_known) ? rd_mux : 32'h0000_0000;
      if (wr_go && wb_req_i.adr == `SS_OFF_CTRL)
        sw_enable_reg <= wb_req_i.dat[0];
      if (wr_go && wb_req_i.adr == `SS_OFF_IRQ_MASK)
        irq_mask_reg <= wb_req_i.dat[3:0];
      if (wr_any && wb_req_i.adr == `SS_OFF_SEL_RUN)
        sel_run_reg <= sel_wr(sel_run_reg);
      if (wr_any && wb_req_i.adr == `SS_OFF_SEL_TWO)
        sel_two_reg <= sel_wr(sel_two_reg);
      if (wr_any && wb_req_i.adr == `SS_OFF_SEL_THR)
        sel_thr_reg <= sel_wr(sel_thr_reg);
    end
  end

  // safety outputs and status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg      <= ST_SPLIT;
      term_o         <= '0;
      drive_enable_o <= 1'b0;
      stop_requested_indication_o <= 1'b0;
      fault_code_o   <= `SS_CODE_NONE;
      irq_stat_reg   <= 4'h0;
    end else if (ce_i) begin
      state_reg      <= state_now;
      term_o         <= term_next;
      drive_enable_o <= enable_now && sw_enable_reg;
      stop_requested_indication_o <= power_ok_i &&
                                     (state_now == ST_STOPPED);
      fault_code_o   <= code_next;
      irq_stat_reg   <= irq_stat_next;
    end
  end

  assign wb_rsp_o.ack = ack_reg;
  assign wb_rsp_o.dat = rdat_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // safety path: a live edge shows on the outputs one cycle later
  split_off_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && (stop_channel_one_i != stop_channel_two_i) |=>
    !drive_enable_o && !term_o.mon_pin)
    else $error("drive or monitor on with channels split");
  fault_off_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && guard_fault_i |=> !drive_enable_o &&
    fault_code_o == `SS_CODE_GUARD)
    else $error("guard fault not handled");
  cpu_code_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && cpu_fault_i && !guard_fault_i |=> !drive_enable_o &&
    fault_code_o == `SS_CODE_CPU)
    else $error("processor fault not handled");

  // a frozen enable keeps its value, so judge it only after a live edge
  enable_cond_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    drive_enable_o && $past(ce_i) |-> $past(power_ok_i) &&
    $past(stop_channel_one_i) && $past(stop_channel_two_i) &&
    !$past(any_fault) && $past(sw_enable_reg))
    else $error("drive enabled without cause");
  stop_ind_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && power_ok_i && !stop_channel_one_i && !stop_channel_two_i &&
    !any_fault |=> stop_requested_indication_o && !drive_enable_o)
    else $error("stop indication missing");
  open_chan_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !stop_channel_one_i |=> !drive_enable_o)
    else $error("open channel left drive on");

  // monitor and health levels on their pins and terminals
  mon_pin_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !routed_mon && power_ok_i && !stop_channel_one_i &&
    !stop_channel_two_i && !any_fault |=> term_o.mon_pin)
    else $error("monitor pin not conducting when stopped");
  mon_fault_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && any_fault |=> !term_o.mon_pin)
    else $error("monitor pin on under fault");
  run_health_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && sel_run_reg == {1'b0, `SS_SEL_HEALTH_POS} && any_fault |=>
    !term_o.run_term)
    else $error("run terminal on under fault");
  health_ok_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && sel_two_reg == {1'b0, `SS_SEL_HEALTH_POS} && power_ok_i &&
    !any_fault && stop_channel_one_i == stop_channel_two_i |=>
    term_o.second_term)
    else $error("health output off without fault");
  health_fault_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && sel_two_reg == {1'b0, `SS_SEL_HEALTH_POS} && any_fault |=>
    !term_o.second_term)
    else $error("health output on under fault");
  neg_mon_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && sel_thr_reg == `SS_SEL_MON_NEG |=>
    term_o.third_term == !$past(mon_on))
    else $error("negative monitor routing wrong");
  neg_health_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && sel_thr_reg == `SS_SEL_HEALTH_NEG |=>
    term_o.third_term == !$past(health_on))
    else $error("negative health routing wrong");
  on_means_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> term_o == $past(term_next))
    else $error("terminal level not registered");

  // clock enable low holds every output level
  hold_ce_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(term_o) && $stable(drive_enable_o) &&
    $stable(stop_requested_indication_o))
    else $error("outputs moved while clock enable low");

  // bus answer is a single cycle pulse
  ack_pulse_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && ack_reg |=> !ack_reg)
    else $error("ack held longer than one cycle");

  // sticky status: an event in the clear cycle still sets its bit
  sticky_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && (ev_now != 4'h0) |=>
    (irq_stat_reg & $past(ev_now)) == $past(ev_now))
    else $error("status event lost");
  w1c_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> (irq_stat_reg & $past(clr_bits) & ~$past(ev_now)) == 4'h0)
    else $error("status bit not cleared by write");

  // main scenarios reached
  cover_enable: cover property (@(posedge clk_i) drive_enable_o);
  cover_stop: cover property (@(posedge clk_i) stop_requested_indication_o);
  cover_fault: cover property (@(posedge clk_i) fault_code_o != 2'h0);
  cover_split: cover property (@(posedge clk_i) state_reg == ST_SPLIT);
  cover_irq: cover property (@(posedge clk_i) irq_o);
endmodule

// >>> common/safety_stop_cfg.svh
// Functional notes
// - an open stop channel requests safety stop; a shorted one does not
// - stop monitor conducts only when stopped without internal fault
// - health output conducts with power good unless an internal safety fault or a channel mismatch exists
// - one channel open: drive off, both status outputs off
// - both open, no fault: drive off, outputs on, stop indication raised
// - internal fault: drive off, outputs off, fault code reported
// - monitor on its own pin; selector 80/180 routes it to a terminal
// - run terminal shows running; selector 81/181 routes health output
// - run selector 81 turns run terminal off on a fault
// - status output ON means its open-collector transistor conducts
`ifndef SAFETY_STOP_CFG_SVH
`define SAFETY_STOP_CFG_SVH

// register byte offsets
`define SS_OFF_CTRL     8'h00
`define SS_OFF_STATUS   8'h04
`define SS_OFF_IRQ_STAT 8'h08
`define SS_OFF_IRQ_MASK 8'h0C
`define SS_OFF_SEL_RUN  8'h10
`define SS_OFF_SEL_TWO  8'h14
`define SS_OFF_SEL_THR  8'h18

// output function selector codes
`define SS_SEL_MON_POS    8'd80
`define SS_SEL_HEALTH_POS 8'd81
`define SS_SEL_MON_NEG    9'd180
`define SS_SEL_HEALTH_NEG 9'd181
`define SS_SEL_RUNNING    9'd0

// reset values
`define SS_SEL_RESET      9'h000
`define SS_MASK_RESET     4'h0

// fault code values reported in status
`define SS_CODE_NONE      2'h0
`define SS_CODE_GUARD     2'h1
`define SS_CODE_CPU       2'h2

// irq bit positions
`define SS_IRQ_STOP       0
`define SS_IRQ_FAULT      1
`define SS_IRQ_MISMATCH   2
`define SS_IRQ_ENABLE     3

`endif

// >>> common/safety_stop_pkg.sv
package safety_stop_pkg;
  // decision outcome of the stop logic
  typedef enum logic [3:0] {
    ST_ENABLED = 4'b0001,
    ST_STOPPED = 4'b0010,
    ST_FAULT   = 4'b0100,
    ST_SPLIT   = 4'b1000
  } stop_state_t;

  // classic wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  // wishbone answer
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // terminal outputs, high means transistor conducts
  typedef struct packed {
    logic mon_pin;
    logic run_term;
    logic second_term;
    logic third_term;
  } term_out_t;
endpackage

// >>> testbench/relay_model.sv
`timescale 1ns/10ps
// safety relay stand-in: opens contacts on command, reads feedback
module relay_model (
  input  wire logic open_one_i,
  input  wire logic open_two_i,
  input  wire logic feedback_i,
  output logic      ch_one_o,
  output logic      ch_two_o,
  output logic      restart_blocked_o
);
  // an open contact is a stop request, so the line reads low
  assign ch_one_o = !open_one_i;
  assign ch_two_o = !open_two_i;
  // lost health feedback keeps restart blocked
  assign restart_blocked_o = !feedback_i;
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import safety_stop_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       power_ok = 1'b1;
  logic       open_one = 1'b0;
  logic       open_two = 1'b0;
  logic       guard_f = 1'b0;
  logic       cpu_f = 1'b0;
  logic       running = 1'b0;
  logic       ce = 1'b1;
  wb_req_t    req = '0;
  wb_rsp_t    rsp;
  term_out_t  term;
  logic       ch_one, ch_two, blocked, de, sr, irq;
  logic [1:0] code;
  logic [31:0] rd;
  logic [7:0] offs [5] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18};
  int         errors = 0;
  int         checks = 0;

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  relay_model partner (.open_one_i(open_one), .open_two_i(open_two),
    .feedback_i(term.run_term), .ch_one_o(ch_one), .ch_two_o(ch_two),
    .restart_blocked_o(blocked));

  safety_stop_monitor dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .power_ok_i(power_ok), .stop_channel_one_i(ch_one),
    .stop_channel_two_i(ch_two), .guard_fault_i(guard_f),
    .cpu_fault_i(cpu_f), .running_i(running), .wb_req_i(req),
    .wb_rsp_o(rsp), .term_o(term), .drive_enable_o(de),
    .stop_requested_indication_o(sr), .fault_code_o(code), .irq_o(irq));

  task print_verdict;
    $display("comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task cmp(input logic [31:0] act, input logic [31:0] exp);
    checks++;
    if (act !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, adr, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    rd = rsp.dat;
    req <= '0;
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
  endtask

  // new input levels, then wait for the registered answer
  task apply(input logic p, a, b, g, c);
    @(posedge clk_i);
    power_ok <= p;
    open_one <= a;
    open_two <= b;
    guard_f <= g;
    cpu_f <= c;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task reset_values;
    cmp({31'h0, de}, 32'h0);
    for (int k = 0; k < 5; k++) begin
      xfer(1'b0, offs[k], '0);
      cmp(rd, 32'h0);
    end
    xfer(1'b0, 8'h04, '0);
    cmp(rd, 32'h0000_0010);
    xfer(1'b0, 8'h08, '0);
    cmp(rd, 32'h0000_0000);
    xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h20, '0);
    cmp(rd, 32'h0);
  endtask

  // every channel and fault combination, health on terminals two/three
  task truth_table;
    logic f, sp, d, s, h;
    logic [1:0] c;
    xfer(1'b1, 8'h00, 32'h0000_0001);
    xfer(1'b1, 8'h14, 32'h0000_0051);
    xfer(1'b1, 8'h18, 32'h0000_00B5);
    for (int i = 0; i < 16; i++) begin
      apply(1'b1, i[0], i[1], i[2], i[3]);
      f = i[2] | i[3];
      sp = i[0] ^ i[1];
      d = !i[0] && !i[1] && !f;
      s = i[0] && i[1] && !f;
      h = !f && !sp;
      c = i[2] ? 2'h1 : (i[3] ? 2'h2 : 2'h0);
      cmp({28'h0, de, sr, code}, {28'h0, d, s, c});
      cmp({28'h0, term}, {28'h0, s, 1'b0, h, !h});
      cmp({31'h0, irq}, 32'h0);
    end
    apply(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cmp({27'h0, de, term}, 32'h0000_0001);
  endtask

  task irq_flow;
    xfer(1'b1, 8'h08, 32'h0000_000F);
    xfer(1'b1, 8'h0C, 32'h0000_0001);
    apply(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    cmp({31'h0, irq}, 32'h0000_0001);
    xfer(1'b0, 8'h04, '0);
    cmp(rd, 32'h0000_0022);
    xfer(1'b1, 8'h08, 32'h0000_0001);
    @(posedge clk_i);
    #1;
    cmp({31'h0, irq}, 32'h0);
    xfer(1'b1, 8'h0C, 32'h0000_0000);
    apply(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    cmp({31'h0, irq}, 32'h0);
    xfer(1'b1, 8'h0C, 32'h0000_0002);
    @(posedge clk_i);
    #1;
    cmp({31'h0, irq}, 32'h0000_0001);
    xfer(1'b0, 8'h04, '0);
    cmp(rd, 32'h0000_0044);
    xfer(1'b1, 8'h0C, 32'h0000_0000);
    apply(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    xfer(1'b0, 8'h04, '0);
    cmp(rd, 32'h0000_0080);
    xfer(1'b0, 8'h08, '0);
    cmp(rd, 32'h0000_0006);
    xfer(1'b1, 8'h08, 32'h0000_0006);
    xfer(1'b0, 8'h08, '0);
    cmp(rd, 32'h0000_0000);
  endtask

  // monitor and health moved to terminals, then defaults again
  task routing;
    xfer(1'b1, 8'h10, 32'h0000_0051);
    xfer(1'b1, 8'h14, 32'h0000_0050);
    xfer(1'b1, 8'h18, 32'h0000_00B4);
    apply(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    cmp({28'h0, term}, 32'h0000_0006);
    cmp({31'h0, blocked}, 32'h0);
    apply(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    cmp({28'h0, term}, 32'h0000_0001);
    cmp({31'h0, blocked}, 32'h0000_0001);
    for (int k = 2; k < 5; k++)
      xfer(1'b1, offs[k], '0);
    @(posedge clk_i);
    running <= 1'b1;
    apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    cmp({27'h0, de, term}, 32'h0000_0014);
    xfer(1'b0, 8'h08, '0);
    cmp(rd, 32'h0000_000B);
  endtask

  // clock enable low holds every output, high lets it follow again
  task freeze_check;
    @(posedge clk_i);
    ce <= 1'b0;
    apply(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    cmp({27'h0, de, term}, 32'h0000_0014);
    @(posedge clk_i);
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    cmp({26'h0, sr, de, term}, 32'h0000_0028);
  endtask

  // reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    truth_table();
    irq_flow();
    routing();
    freeze_check();
    print_verdict();
  end
endmodule
